// file: lsr_defines.svh
`ifndef LSR_DEFINES_SVH
`define LSR_DEFINES_SVH

// timing
`define LSR_PCLK_MHZ     200
`define LSR_FRAME_MS     100
`define LSR_SAMPLE_US    300
`define LSR_FRAME_CYC    (`LSR_FRAME_MS * 1000 * `LSR_PCLK_MHZ)
`define LSR_SAMPLE_CYC   (`LSR_SAMPLE_US * `LSR_PCLK_MHZ)
`define LSR_SCL_QTR_CYC  125

// bus addressing
`define LSR_DEV_ADDR     7'h13
`define LSR_WR_ADDR_BYTE {`LSR_DEV_ADDR, 1'b0}
`define LSR_RD_ADDR_BYTE {`LSR_DEV_ADDR, 1'b1}
`define LSR_BIT_ACK      4'h8
`define LSR_BIT_END      4'h9

// sensor register pointers
`define LSR_REG_CMD      8'h80
`define LSR_REG_IRCUR    8'h83
`define LSR_REG_AMBPAR   8'h84
`define LSR_REG_AMBHI    8'h85
`define LSR_REG_AMBLO    8'h86
`define LSR_REG_AMBIR    8'h90

// sensor register fields
`define LSR_CMD_AMB_REQ  0
`define LSR_CMD_PROX_REQ 1
`define LSR_CMD_AMB_RDY  6
`define LSR_PAR_CONT     7
`define LSR_AVG_MSB      2
`define LSR_AVG_LSB      0

// controller apb map
`define LSR_H_CTRL       8'h00
`define LSR_H_DATA       8'h04
`define LSR_H_STAT       8'h08
`define LSR_H_RDATA      8'h0C
`define LSR_HC_GO        0
`define LSR_HC_READ      1
`define LSR_HC_SEP       2
`define LSR_HC_TWO       3
`define LSR_HS_BUSY      0
`define LSR_HS_NACK      1
`define LSR_HS_REFUSED   2

`endif

// file: lsr_pkg.sv
package lsr_pkg;

   typedef enum logic [2:0] {
      DS_IDLE, DS_ADDR, DS_PTR, DS_WDATA, DS_READ
   } lsr_slv_e;

   typedef enum logic [1:0] {MS_IDLE, MS_SAMPLE, MS_WAIT} lsr_meas_e;

   typedef enum logic [1:0] {HP_IDLE, HP_START, HP_BIT, HP_STOP} lsr_hph_e;

   typedef enum logic [2:0] {
      HG_ADW, HG_PTR, HG_WD, HG_ADR, HG_RD
   } lsr_hstg_e;

   typedef struct packed {
      logic        scl_s1, scl_s2, scl_p;
      logic        sda_s1, sda_s2, sda_p;
      lsr_slv_e    slv;
      logic [3:0]  bitcnt;
      logic [7:0]  shift;
      logic        rw, nack, sda_oe;
      logic [7:0]  ptr;
      logic        amb_req, prox_req, amb_rdy, cont;
      logic [2:0]  avg;
      logic [7:0]  ircur;
      logic [15:0] res;
      lsr_meas_e   meas;
      logic [31:0] frame_cnt, smp_cnt, prox_cnt;
      logic [7:0]  nsmp;
      logic [22:0] acc;
      logic        smp_stb, standby, ir_on;
   } lsr_dev_s;

   typedef struct packed {
      logic        pready, pslverr;
      logic [31:0] prdata;
      logic        rd, sep, two;
      logic [7:0]  ptr, wd;
      logic        busy, nack, refused, rs_pend;
      logic [15:0] rdata;
      logic        sda_s1, sda_s2;
      lsr_hph_e    phase;
      lsr_hstg_e   stage;
      logic [15:0] qcnt;
      logic [1:0]  qtr;
      logic [3:0]  bidx;
      logic [8:0]  sh, rx;
      logic        left, scl, sda_oe;
   } lsr_host_s;

endpackage : lsr_pkg

// file: lsr_i2c_if.sv
`timescale 1ns/1ps
interface lsr_i2c_if;
   logic scl;
   logic h_sda_o;
   logic h_sda_oe;
   logic d_sda_o;
   logic d_sda_oe;
   logic sda_in;

   // open drain: any enabled low driver pulls the line down
   assign sda_in = ~((h_sda_oe & ~h_sda_o) | (d_sda_oe & ~d_sda_o));

   modport dev  (input scl, input sda_in,
                 output d_sda_o, output d_sda_oe);
   modport host (output scl, output h_sda_o, output h_sda_oe,
                 input sda_in);
endinterface : lsr_i2c_if

// file: lsr_dev.sv
`timescale 1ns/1ps
`include "lsr_defines.svh"
// How it works
// - no request: standby, only bus alive
// - emitter sink off in standby always
// - host writes pointer alone, then reads
// - stop plus start or repeated start
// - pointer advances after every byte read
// - ambient fetch: 26h,85h then 27h reads
// - standard mode: cycle within 100 ms
// - each ambient sample about 300 us
// - average configured count, up to 128
// - standard result never before 100 ms
// - continuous mode: samples back to back
// - host refuses any transfer that starts at register 90h
module lsr_dev #(
   parameter int FRAME_CYC  = `LSR_FRAME_CYC,
   parameter int SAMPLE_CYC = `LSR_SAMPLE_CYC
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   lsr_i2c_if.dev           bus,
   input  wire logic [15:0] light_level,
   output logic             sample_start,
   output logic             standby,
   output logic             ir_sink_on,
   output logic [15:0]      amb_result
);
   import lsr_pkg::*;

   lsr_dev_s   q;
   lsr_dev_s   d;
   logic       scl_rise;
   logic       scl_fall;
   logic       i2c_start;
   logic       i2c_stop;
   logic [7:0] rd_byte;
   logic [22:0] acc_next;

   ////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] reg_rd(lsr_dev_s s);
      reg_rd = 8'h00;
      case (s.ptr)
         `LSR_REG_CMD: begin
            reg_rd[`LSR_CMD_AMB_REQ]  = s.amb_req;
            reg_rd[`LSR_CMD_PROX_REQ] = s.prox_req;
            reg_rd[`LSR_CMD_AMB_RDY]  = s.amb_rdy;
         end
         `LSR_REG_IRCUR:  reg_rd = s.ircur;
         `LSR_REG_AMBPAR: begin
            reg_rd[`LSR_PAR_CONT]                 = s.cont;
            reg_rd[`LSR_AVG_MSB:`LSR_AVG_LSB]     = s.avg;
         end
         `LSR_REG_AMBHI:  reg_rd = s.res[15:8];
         `LSR_REG_AMBLO:  reg_rd = s.res[7:0];
         // reserved ambient ir level reads zero here
         default:         reg_rd = 8'h00;
      endcase
   endfunction : reg_rd

   function automatic logic [7:0] n_avg(logic [2:0] e);
      n_avg = 8'(8'h01 << e);
   endfunction : n_avg

   function automatic logic [15:0] avg_of(logic [22:0] a, logic [2:0] e);
      avg_of = 16'(a >> e);
   endfunction : avg_of

   ////////////////////////////////////////////////////////////////////////
   // only second stage and its delayed copy feed edge logic
   assign scl_rise  = q.scl_s2 & ~q.scl_p;
   assign scl_fall  = ~q.scl_s2 & q.scl_p;
   assign i2c_start = q.scl_s2 & q.scl_p & q.sda_p & ~q.sda_s2;
   assign i2c_stop  = q.scl_s2 & q.scl_p & ~q.sda_p & q.sda_s2;
   assign rd_byte   = reg_rd(q);
   assign acc_next  = q.acc + {7'h00, light_level};

   always_comb begin
      d         = q;
      d.smp_stb = 1'b0;
      d.scl_s1  = bus.scl;
      d.scl_s2  = q.scl_s1;
      d.scl_p   = q.scl_s2;
      d.sda_s1  = bus.sda_in;
      d.sda_s2  = q.sda_s1;
      d.sda_p   = q.sda_s2;

      /////////////////////////////////////////////////////////////////////
      // serial slave, alive in standby too
      if (i2c_start) begin
         // same path for a fresh start and a repeated start
         d.slv    = DS_ADDR;
         d.bitcnt = 4'h0;
         d.sda_oe = 1'b0;
      end else if (i2c_stop) begin
         d.slv    = DS_IDLE;
         d.sda_oe = 1'b0;
      end else if (q.slv != DS_IDLE) begin
         if (scl_rise) begin
            if (q.bitcnt == `LSR_BIT_ACK)
               d.nack = q.sda_s2;
            else if (q.slv != DS_READ && q.bitcnt < `LSR_BIT_ACK)
               d.shift = {q.shift[6:0], q.sda_s2};
            if (q.bitcnt != `LSR_BIT_END)
               d.bitcnt = q.bitcnt + 4'h1;
         end
         if (scl_fall) begin
            if (q.bitcnt == `LSR_BIT_ACK) begin
               d.sda_oe = 1'b0;
               case (q.slv)
                  DS_ADDR: begin
                     if (q.shift[7:1] == `LSR_DEV_ADDR) begin
                        d.sda_oe = 1'b1;
                        d.rw     = q.shift[0];
                     end else begin
                        d.slv = DS_IDLE;
                     end
                  end
                  DS_PTR: begin
                     // a write that stops here only sets the pointer
                     d.sda_oe = 1'b1;
                     d.ptr    = q.shift;
                  end
                  DS_WDATA: begin
                     d.sda_oe = 1'b1;
                     d.ptr    = q.ptr + 8'h01;
                     case (q.ptr)
                        `LSR_REG_CMD: begin
                           d.amb_req  = q.shift[`LSR_CMD_AMB_REQ];
                           d.prox_req = q.shift[`LSR_CMD_PROX_REQ];
                           if (q.shift[`LSR_CMD_AMB_REQ])
                              d.amb_rdy = 1'b0;
                        end
                        `LSR_REG_IRCUR: d.ircur = q.shift;
                        `LSR_REG_AMBPAR: begin
                           d.cont = q.shift[`LSR_PAR_CONT];
                           d.avg  = q.shift[`LSR_AVG_MSB:`LSR_AVG_LSB];
                        end
                        default: ;
                     endcase
                  end
                  default: ;
               endcase
            end else if (q.bitcnt == `LSR_BIT_END) begin
               d.sda_oe = 1'b0;
               d.bitcnt = 4'h0;
               case (q.slv)
                  DS_ADDR:  d.slv = q.rw ? DS_READ : DS_PTR;
                  DS_PTR:   d.slv = DS_WDATA;
                  DS_READ:  d.slv = q.nack ? DS_IDLE : DS_READ;
                  default:  ;
               endcase
               if ((q.slv == DS_ADDR && q.rw) ||
                   (q.slv == DS_READ && !q.nack)) begin
                  // load then step, so the next read sees the next one
                  d.shift  = rd_byte;
                  d.sda_oe = ~rd_byte[7];
                  d.ptr    = q.ptr + 8'h01;
               end
            end else if (q.slv == DS_READ && q.bitcnt != 4'h0) begin
               d.shift  = {q.shift[6:0], 1'b0};
               d.sda_oe = ~q.shift[6];
            end
         end
      end

      /////////////////////////////////////////////////////////////////////
      // ambient conversion
      if (q.meas != MS_IDLE && q.frame_cnt != 32'(FRAME_CYC - 1))
         d.frame_cnt = q.frame_cnt + 32'h1;
      case (q.meas)
         MS_IDLE: begin
            if (q.amb_req) begin
               d.meas      = MS_SAMPLE;
               d.acc       = 23'h0;
               d.frame_cnt = 32'h0;
               d.smp_cnt   = 32'h0;
               d.nsmp      = 8'h00;
               d.smp_stb   = 1'b1;
            end
         end
         MS_SAMPLE: begin
            d.smp_cnt = q.smp_cnt + 32'h1;
            if (q.smp_cnt == 32'(SAMPLE_CYC - 1)) begin
               d.smp_cnt = 32'h0;
               d.acc     = acc_next;
               d.nsmp    = q.nsmp + 8'h01;
               if (8'(q.nsmp + 8'h01) == n_avg(q.avg)) begin
                  if (q.cont) begin
                     // no frame wait in continuous mode
                     d.res     = avg_of(acc_next, q.avg);
                     d.amb_rdy = 1'b1;
                     d.amb_req = 1'b0;
                     d.meas    = MS_IDLE;
                  end else begin
                     d.meas = MS_WAIT;
                  end
               end else begin
                  // next sample starts at once in both modes
                  d.smp_stb = 1'b1;
               end
            end
         end
         MS_WAIT: begin
            // result held back to the frame end, any count
            if (q.frame_cnt == 32'(FRAME_CYC - 1)) begin
               d.res     = avg_of(q.acc, q.avg);
               d.amb_rdy = 1'b1;
               d.amb_req = 1'b0;
               d.meas    = MS_IDLE;
            end
         end
         default: d.meas = MS_IDLE;
      endcase

      /////////////////////////////////////////////////////////////////////
      // proximity pulse: modulator itself lives elsewhere
      if (q.prox_req) begin
         d.prox_cnt = q.prox_cnt + 32'h1;
         if (q.prox_cnt == 32'(SAMPLE_CYC - 1)) begin
            d.prox_cnt = 32'h0;
            d.prox_req = 1'b0;
         end
      end

      d.standby = !(d.amb_req || d.prox_req) && d.meas == MS_IDLE;
      // current setting is ignored while idle, no rewrite needed
      d.ir_on   = !d.standby && d.prox_req && d.ircur != 8'h00;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q         <= '0;
         q.scl_s1  <= 1'b1;
         q.scl_s2  <= 1'b1;
         q.scl_p   <= 1'b1;
         q.sda_s1  <= 1'b1;
         q.sda_s2  <= 1'b1;
         q.sda_p   <= 1'b1;
         q.standby <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign bus.d_sda_o  = 1'b0;
   assign bus.d_sda_oe = q.sda_oe;
   assign sample_start = q.smp_stb;
   assign standby      = q.standby;
   assign ir_sink_on   = q.ir_on;
   assign amb_result   = q.res;

endmodule : lsr_dev

// file: lsr_host.sv
`timescale 1ns/1ps
`include "lsr_defines.svh"
module lsr_host #(
   parameter int QTR_CYC = `LSR_SCL_QTR_CYC
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   lsr_i2c_if.host          bus
);
   import lsr_pkg::*;

   lsr_host_s q;
   lsr_host_s d;
   logic      acc_ph;
   logic      qtr_end;

   assign acc_ph  = psel & penable;
   assign qtr_end = q.phase != HP_IDLE && q.qcnt == 16'(QTR_CYC - 1);

   always_comb begin
      d         = q;
      d.sda_s1  = bus.sda_in;
      d.sda_s2  = q.sda_s1;
      d.pready  = acc_ph & ~q.pready;
      d.pslverr = 1'b0;
      d.prdata  = 32'h0;

      /////////////////////////////////////////////////////////////////////
      // apb: answer one cycle into the access phase
      if (acc_ph && !q.pready) begin
         case (paddr)
            `LSR_H_CTRL: begin
               d.prdata[`LSR_HC_READ] = q.rd;
               d.prdata[`LSR_HC_SEP]  = q.sep;
               d.prdata[`LSR_HC_TWO]  = q.two;
            end
            `LSR_H_DATA:  d.prdata = {16'h0, q.wd, q.ptr};
            `LSR_H_STAT: begin
               d.prdata[`LSR_HS_BUSY]    = q.busy;
               d.prdata[`LSR_HS_NACK]    = q.nack;
               d.prdata[`LSR_HS_REFUSED] = q.refused;
            end
            `LSR_H_RDATA: d.prdata = {16'h0, q.rdata};
            default:      d.pslverr = 1'b1;
         endcase
      end
      // writes while busy are dropped so a transfer is never torn
      if (acc_ph && q.pready && pwrite && !q.busy) begin
         if (paddr == `LSR_H_DATA) begin
            d.ptr = pwdata[7:0];
            d.wd  = pwdata[15:8];
         end
         if (paddr == `LSR_H_CTRL) begin
            d.rd  = pwdata[`LSR_HC_READ];
            d.sep = pwdata[`LSR_HC_SEP];
            d.two = pwdata[`LSR_HC_TWO];
            if (pwdata[`LSR_HC_GO]) begin
               if (q.ptr == `LSR_REG_AMBIR) begin
                  d.refused = 1'b1;
               end else begin
                  d.busy    = 1'b1;
                  d.nack    = 1'b0;
                  d.refused = 1'b0;
                  d.rdata   = 16'h0;
                  d.phase   = HP_START;
                  d.stage   = HG_ADW;
                  d.qcnt    = 16'h0;
                  d.qtr     = 2'h0;
               end
            end
         end
      end

      /////////////////////////////////////////////////////////////////////
      // bit sequencer, four quarters per phase
      if (q.phase != HP_IDLE) begin
         d.qcnt = q.qcnt + 16'h1;
         if (qtr_end) begin
            d.qcnt = 16'h0;
            d.qtr  = q.qtr + 2'h1;
            if (q.phase == HP_BIT && q.qtr == 2'h1)
               d.rx = {q.rx[7:0], q.sda_s2};
            if (q.qtr == 2'h3) begin
               case (q.phase)
                  HP_START: begin
                     d.phase = HP_BIT;
                     d.bidx  = 4'h0;
                     d.sh    = (q.stage == HG_ADR) ?
                               {`LSR_RD_ADDR_BYTE, 1'b1} :
                               {`LSR_WR_ADDR_BYTE, 1'b1};
                  end
                  HP_BIT: begin
                     d.sh   = {q.sh[7:0], 1'b1};
                     d.bidx = q.bidx + 4'h1;
                     if (q.bidx == `LSR_BIT_ACK) begin
                        d.bidx  = 4'h0;
                        d.phase = HP_STOP;
                        if (q.stage != HG_RD && q.rx[0]) begin
                           d.nack    = 1'b1;
                           d.rs_pend = 1'b0;
                        end else begin
                           case (q.stage)
                              HG_ADW: begin
                                 // pointer byte next, data byte behind it only for writes
                                 d.phase = HP_BIT;
                                 d.stage = HG_PTR;
                                 d.sh    = {q.ptr, 1'b1};
                              end
                              HG_PTR: begin
                                 if (!q.rd) begin
                                    d.phase = HP_BIT;
                                    d.stage = HG_WD;
                                    d.sh    = {q.wd, 1'b1};
                                 end else begin
                                    // stop then start, or repeated start
                                    d.stage   = HG_ADR;
                                    d.rs_pend = q.sep;
                                    d.phase   = q.sep ? HP_STOP : HP_START;
                                 end
                              end
                              HG_ADR: begin
                                 d.phase = HP_BIT;
                                 d.stage = HG_RD;
                                 d.left  = q.two;
                                 d.sh    = {8'hFF, ~q.two};
                              end
                              HG_RD: begin
                                 // of two bytes the first lands high, next low; a single byte lands low
                                 d.rdata = {q.rdata[7:0], q.rx[8:1]};
                                 if (q.left) begin
                                    d.phase = HP_BIT;
                                    d.left  = 1'b0;
                                    d.sh    = 9'h1FF;
                                 end
                              end
                              default: ;
                           endcase
                        end
                     end
                  end
                  HP_STOP: begin
                     d.rs_pend = 1'b0;
                     d.phase   = q.rs_pend ? HP_START : HP_IDLE;
                     d.busy    = q.rs_pend;
                  end
                  default: d.phase = HP_IDLE;
               endcase
            end
         end
      end

      case (d.phase)
         HP_START: begin
            d.scl    = d.qtr == 2'h1 || d.qtr == 2'h2;
            d.sda_oe = d.qtr[1];
         end
         HP_BIT: begin
            d.scl    = d.qtr == 2'h1 || d.qtr == 2'h2;
            d.sda_oe = ~d.sh[8];
         end
         HP_STOP: begin
            d.scl    = d.qtr != 2'h0;
            d.sda_oe = ~d.qtr[1];
         end
         default: begin
            d.scl    = 1'b1;
            d.sda_oe = 1'b0;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q        <= '0;
         q.scl    <= 1'b1;
         q.sda_s1 <= 1'b1;
         q.sda_s2 <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign prdata      = q.prdata;
   assign pready      = q.pready;
   assign pslverr     = q.pslverr;
   assign bus.scl     = q.scl;
   assign bus.h_sda_o = 1'b0;
   assign bus.h_sda_oe = q.sda_oe;

endmodule : lsr_host

// file: lsr_chk_asserts.sv
`timescale 1ns/1ps
module lsr_chk #(
   parameter int SAMPLE_CYC = 20
) (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        scl,
   input wire logic        d_sda_oe,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [7:0]  paddr,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        sample_start,
   input wire logic        standby,
   input wire logic        ir_sink_on,
   input wire logic [15:0] amb_result
);
   logic [15:0] gap_q;
   default clocking dck @(posedge pclk); endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////////////////////////////////
   // cycles since last sample start, saturates so idle never wraps
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         gap_q <= 16'hFFFF;
      else if (sample_start)
         gap_q <= 16'h0001;
      else if (gap_q != 16'hFFFF)
         gap_q <= gap_q + 16'h0001;
   end
   ////////////////////////////////////////////////////////////////////
   a_ir_off_stby: assert property (standby |-> !ir_sink_on)
      else $error("ir sink on in standby");
   a_res_awake: assert property (
      $changed(amb_result) |-> !$past(standby))
      else $error("result changed while in standby");
   a_smp_gap: assert property (
      sample_start |-> gap_q >= SAMPLE_CYC)
      else $error("sample started too early");
   a_res_gap: assert property (
      $changed(amb_result) |-> gap_q >= SAMPLE_CYC - 1)
      else $error("result published mid sample");
   a_sda_scl_low: assert property ($changed(d_sda_oe) |-> !scl)
      else $error("device moved sda with scl high");
   a_rdy_one: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_rdy_wait: assert property (psel && !penable |=> !pready ##1 pready)
      else $error("pready not on second access cycle");
   a_bad_addr: assert property (psel && penable && pready |->
      pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C}))
      else $error("pslverr wrong for address");
endmodule : lsr_chk

// file: light_sensor_read_and_conversion_test.sv
`timescale 1ns/1ps
module light_sensor_read_and_conversion_test;
   localparam int FRM = 2000;
   localparam int SMP = 200;
   logic        pclk, presetn, psel, penable, pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, st;
   logic        pready, pslverr, sample_start, standby, ir_sink_on;
   logic        last_err, ir_seen;
   logic [15:0] light_level, amb_result;
   int          errors, checks_done, smp_n, cyc, t_first;
   lsr_i2c_if i2c();
   lsr_dev #(.FRAME_CYC(FRM), .SAMPLE_CYC(SMP)) u_lsr_dev (
      .pclk(pclk), .presetn(presetn), .bus(i2c),
      .light_level(light_level), .sample_start(sample_start),
      .standby(standby), .ir_sink_on(ir_sink_on),
      .amb_result(amb_result));
   lsr_host #(.QTR_CYC(8)) u_lsr_host (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .bus(i2c));
   lsr_chk #(.SAMPLE_CYC(SMP)) u_lsr_chk (
      .pclk(pclk), .presetn(presetn), .scl(i2c.scl),
      .d_sda_oe(i2c.d_sda_oe), .psel(psel), .penable(penable),
      .paddr(paddr), .pready(pready), .pslverr(pslverr),
      .sample_start(sample_start), .standby(standby),
      .ir_sink_on(ir_sink_on), .amb_result(amb_result));
   ////////////////////////////////////////////////////////////////////
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   // nba on cyc and t_first only; smp_n and ir_seen update at once
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (sample_start === 1'b1) begin
         if (smp_n == 0)
            t_first <= cyc;
         smp_n++;
      end
      if (ir_sink_on === 1'b1)
         ir_seen = 1'b1;
   end
   ////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] s, e);
      checks_done++;
      if (s !== e) begin
         errors++;
         $display("mismatch %s exp %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic test_done;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : test_done
   task automatic lim(input int n, input int l);
      if (n >= l) begin
         chk("wait_limit", 1, 0);
         test_done();
      end
   endtask : lim
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      r = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      lim(n, 50);
   endtask : apb
   // c: b0 go, b1 read, b2 stop+start, b3 two bytes
   task automatic xfer(input logic [3:0] c, input logic [7:0] p, wd,
                       output logic [31:0] r);
      int n;
      n = 0;
      apb(1'b1, 8'h04, {16'h0000, wd, p}, r);
      apb(1'b1, 8'h00, {28'h0000000, c}, r);
      do begin
         apb(1'b0, 8'h08, 32'h0, st);
         n++;
      end while (st[0] !== 1'b0 && n < 2000);
      lim(n, 2000);
      apb(1'b0, 8'h0C, 32'h0, r);
   endtask : xfer
   task automatic wait_res(input logic [15:0] old, output int dt);
      int n;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (amb_result === old && n < 3 * FRM);
      lim(n, 3 * FRM);
      dt = cyc - t_first;
   endtask : wait_res
   ////////////////////////////////////////////////////////////////////
   task automatic t_idle;
      logic [31:0] r;
      chk("standby", standby, 1);
      xfer(4'h1, 8'h83, 8'hFF, r);
      chk("ir_sink_on", ir_sink_on, 0);
      xfer(4'h3, 8'h83, 8'h00, r);
      chk("ircur_rd", r, 32'h000000FF);
      xfer(4'h1, 8'h80, 8'h02, r);
      repeat (2 * SMP) @(posedge pclk);
      chk("ir_seen", ir_seen, 1);
      chk("standby_back", standby, 1);
      $display("test idle done");
   endtask : t_idle
   task automatic t_std;
      logic [31:0] r;
      int n, dt;
      n = 0;
      xfer(4'h1, 8'h84, 8'h01, r);
      smp_n = 0;
      xfer(4'h1, 8'h80, 8'h01, r);
      while (smp_n < 2 && n < 4 * SMP) begin
         @(posedge pclk);
         n++;
      end
      lim(n, 4 * SMP);
      chk("awake", standby, 0);
      light_level <= 16'd3000;
      wait_res(16'h0000, dt);
      chk("frame_min", dt >= FRM - 4, 1);
      chk("frame_max", dt <= FRM + 4, 1);
      chk("smp_n", smp_n, 2);
      chk("avg", amb_result, 16'd2000);
      xfer(4'hB, 8'h85, 8'h00, r);
      chk("rd_rs", r, 32'd2000);
      xfer(4'hF, 8'h85, 8'h00, r);
      chk("rd_sep", r, 32'd2000);
      xfer(4'h3, 8'h80, 8'h00, r);
      chk("rdy_bit", r, 32'h00000040);
      chk("standby_end", standby, 1);
      $display("test standard done");
   endtask : t_std
   task automatic t_cont;
      logic [31:0] r;
      int dt;
      xfer(4'h1, 8'h84, 8'h83, r);
      light_level <= 16'h0F0F;
      smp_n = 0;
      xfer(4'h1, 8'h80, 8'h01, r);
      wait_res(16'd2000, dt);
      chk("b2b_max", dt <= 8 * SMP + 4, 1);
      chk("b2b_min", dt >= 8 * SMP - 4, 1);
      chk("smp_n", smp_n, 8);
      chk("avg", amb_result, 16'h0F0F);
      $display("test continuous done");
   endtask : t_cont
   task automatic t_refuse;
      logic [31:0] r;
      xfer(4'h3, 8'h90, 8'h00, r);
      chk("refused", st[2], 1);
      apb(1'b0, 8'h10, 32'h0, r);
      chk("pslverr", last_err, 1);
      $display("test refuse done");
   endtask : t_refuse
   ////////////////////////////////////////////////////////////////////
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      light_level = 16'd1000;
      presetn = 1'b0;
      errors = 0;
      checks_done = 0;
      smp_n = 0;
      cyc = 0;
      t_first = 0;
      ir_seen = 1'b0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      t_idle();
      t_std();
      t_cont();
      t_refuse();
      test_done();
   end
endmodule : light_sensor_read_and_conversion_test
